// File: dv/mvrc_breaker_model.sv
// behavioural circuit breaker facing the reclose sequencer
// assumes trip and close commands are synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none

module mvrc_breaker_model (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic protTrip,
  input  wire logic closeCmd,
  input  wire logic readyEn,
  input  wire logic openEn,
  output logic      breakerOpenIn,
  output logic      breakerReadyIn
);
  logic isOpen;

  ////////////////////////////////////////////////////////////////////////////////
  // contacts open on any trip and close on the close command
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      isOpen <= 1'b0;
    else if (protTrip)
      isOpen <= 1'b1;
    else if (closeCmd)
      isOpen <= 1'b0;
  end

  // open status may be withheld so a missing open detection can be shown
  assign breakerOpenIn  = isOpen & openEn;
  // ready means a charged mechanism, not the contact position, so a
  // pickup without trip still finds the breaker ready for the next shot
  assign breakerReadyIn = readyEn;
endmodule

`default_nettype wire

// File: dv/testbench.sv
// self-checking bench of the reclose sequencer with a breaker model
// assumes a shortened millisecond tick of four clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "mvrc_regs.svh"

module testbench;
  import mvrc_pkg::*;
  localparam int TC = 4;
  logic        core_clk = 0, rstn = 0;
  logic [7:0]  regAddr = 0;
  logic [31:0] regWdata = 0;
  logic        regWrite = 0, regRead = 0;
  logic [31:0] regRdata;
  logic        protTrip = 0, protPickup = 0, earthFaultIn = 0, recloseStartIn = 1;
  logic        syncReleaseIn = 1, syncSwitchIn = 0, blockIn = 0, manualCloseIn = 0;
  logic        readyEn = 1, openEn = 1, breakerOpenIn, breakerReadyIn;
  logic        closeCmd, syncSwitchReq, finalTrip, accelTrip, seqActive;
  logic [1:0]  shotNum;
  mvrc_state_type seqState;
  logic        closeSeen = 0, swReqSeen = 0;
  int          fails = 0, checks = 0;
  int          n, w, dt, ef;
  int unsigned seed;
  logic [7:0]  tOfs [8] = '{`MVRC_RECLAIM_OFS, `MVRC_CLOSE_OFS, `MVRC_MANBLK_OFS,
                            `MVRC_STARTMAX_OFS, `MVRC_CBWAIT_OFS, `MVRC_SYNCWAIT_OFS,
                            `MVRC_SWWAIT_OFS, `MVRC_STARTDLY_OFS};
  int          tVal [8] = '{20, 3, 10, 10, 5, 5, 5, 0};

  ////////////////////////////////////////////////////////////////////////////////
  // clock and sticky event flags
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (closeCmd === 1'b1) closeSeen <= 1'b1;
    if (syncSwitchReq === 1'b1) swReqSeen <= 1'b1;
  end

  mvrc_sequencer #(.TICK_CYCLES(TC)) DUT (
    .core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .protTrip(protTrip),
    .protPickup(protPickup), .earthFaultIn(earthFaultIn), .recloseStartIn(recloseStartIn),
    .breakerOpenIn(breakerOpenIn), .breakerReadyIn(breakerReadyIn),
    .syncReleaseIn(syncReleaseIn), .syncSwitchIn(syncSwitchIn), .blockIn(blockIn),
    .manualCloseIn(manualCloseIn), .closeCmd(closeCmd), .syncSwitchReq(syncSwitchReq),
    .finalTrip(finalTrip), .accelTrip(accelTrip), .seqActive(seqActive),
    .shotNum(shotNum), .seqState(seqState));

  mvrc_breaker_model BRK (
    .core_clk(core_clk), .rstn(rstn), .protTrip(protTrip), .closeCmd(closeCmd),
    .readyEn(readyEn), .openEn(openEn), .breakerOpenIn(breakerOpenIn),
    .breakerReadyIn(breakerReadyIn));

  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chk("regRdata", exp, regRdata);
  endtask
  // trip pulse followed by its reset, the default start condition
  task automatic fault;
    @(posedge core_clk);
    protTrip <= 1'b1;
    cyc(2);
    protTrip <= 1'b0;
  endtask
  task automatic waitClose(input int mx, output int c);
    c = 0;
    #1;
    while (closeCmd !== 1'b1 && c < mx) begin
      @(posedge core_clk);
      #1;
      c++;
    end
  endtask
  task automatic results;
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog sized well above the whole sequence
  initial begin
    #300000;
    fails++;
    results();
  end

  initial begin
    seed = $urandom(21639);
    cyc(5);
    rstn <= 1'b1;
    #1;
    chk("seqState", MVRC_IDLE, seqState);
    chk("closeCmd", 0, closeCmd);
    rd(`MVRC_CTRL_OFS, 32'h025);
    rd(`MVRC_DEAD_OFS, 32'd500);
    rd(8'hfc, 32'h0);
    wr(`MVRC_STATUS_OFS, 32'hffff);
    rd(`MVRC_STATUS_OFS, 32'h1);
    for (int i = 0; i < 8; i++) wr(tOfs[i], 32'(tVal[i]));
    rd(`MVRC_RECLAIM_OFS, 32'd20);
    // random fault type and dead time; the other set is far off
    for (int k = 0; k < 4; k++) begin
      ef = $urandom % 2;
      dt = 5 + $urandom % 20;
      wr(`MVRC_DEAD_OFS + 8'(16 * ef), 32'(dt));
      wr(`MVRC_DEAD_OFS + 8'(16 * (1 - ef)), 32'(dt + 30));
      earthFaultIn <= 1'(ef);
      fault();
      waitClose(400, n);
      chk("dead time", 1, 32'(n >= (dt - 1) * TC && n <= (dt + 1) * TC + 8));
      w = 0;
      while (closeCmd === 1'b1 && w < 100) begin
        @(posedge core_clk);
        #1;
        w++;
      end
      chk("close width", 1, 32'(w >= 2 * TC && w <= 4 * TC));
      cyc(24 * TC);
      #1;
      chk("seqState", MVRC_IDLE, seqState);
    end
    // four phase shots, pickup on the second, trip held after the last
    for (int s = 0; s < 4; s++) wr(`MVRC_DEAD_OFS + 8'(4 * s), 32'(5 + s));
    wr(`MVRC_CTRL_OFS, 32'h585);
    earthFaultIn <= 1'b0;
    fault();
    for (int s = 0; s < 4; s++) begin
      waitClose(400, n);
      chk("closeCmd", 1, closeCmd);
      chk("shotNum", s, shotNum);
      chk("accelTrip", s % 2 == 0, accelTrip);
      @(posedge core_clk);
      if (s == 1) protPickup <= 1'b1;
      else protTrip <= 1'b1;
      cyc(2);
      #1;
      if (s != 1) chk("close withdrawn", 0, closeCmd);
      cyc(4 * TC);
      #1;
      if (s == 3) chk("finalTrip", 1, finalTrip);
      closeSeen = 1'b0;
      @(posedge core_clk);
      protPickup <= 1'b0;
      if (s < 3) protTrip <= 1'b0;
    end
    @(posedge core_clk);
    protTrip <= 1'b0;
    cyc(30 * TC);
    #1;
    chk("no fifth close", 0, closeSeen);
    chk("seqState", MVRC_IDLE, seqState);
    // block mid-sequence and while a fault arrives
    wr(`MVRC_CTRL_OFS, 32'h025);
    fault();
    cyc(3);
    blockIn <= 1'b1;
    cyc(2);
    #1;
    chk("seqActive", 0, seqActive);
    chk("shotNum", 0, shotNum);
    fault();
    cyc(2);
    #1;
    chk("seqActive", 0, seqActive);
    @(posedge core_clk) blockIn <= 1'b0;
    // operation off
    wr(`MVRC_CTRL_OFS, 32'h024);
    closeSeen = 1'b0;
    fault();
    cyc(100);
    chk("closeSeen", 0, closeSeen);
    wr(`MVRC_CTRL_OFS, 32'h025);
    // breaker never ready
    readyEn <= 1'b0;
    fault();
    cyc(300);
    #1;
    chk("closeSeen", 0, closeSeen);
    chk("seqState", MVRC_IDLE, seqState);
    // no sync release, then synchronous switching refused and achieved
    @(posedge core_clk) readyEn <= 1'b1;
    syncReleaseIn <= 1'b0;
    fault();
    cyc(300);
    chk("swReqSeen", 1, swReqSeen);
    chk("closeSeen", 0, closeSeen);
    syncSwitchIn <= 1'b1;
    fault();
    waitClose(400, n);
    chk("closeCmd", 1, closeCmd);
    cyc(30 * TC);
    syncReleaseIn <= 1'b1;
    syncSwitchIn <= 1'b0;
    // start on breaker open: no open status means no close
    wr(`MVRC_CTRL_OFS, 32'h027);
    openEn <= 1'b0;
    closeSeen = 1'b0;
    fault();
    cyc(200);
    chk("closeSeen", 0, closeSeen);
    openEn <= 1'b1;
    fault();
    waitClose(400, n);
    chk("closeCmd", 1, closeCmd);
    cyc(30 * TC);
    // manual close inhibit
    manualCloseIn <= 1'b1;
    cyc(2);
    manualCloseIn <= 1'b0;
    fault();
    #1;
    chk("seqActive", 0, seqActive);
    cyc(12 * TC);
    fault();
    #1;
    chk("seqActive", 1, seqActive);
    results();
  end
endmodule

`default_nettype wire

// File: verilog/mvrc_ms_timer.sv
// saturating millisecond timer with a compare limit
// assumes one tick pulse per millisecond from the parent
`timescale 1ns/1ps
`default_nettype none

module mvrc_ms_timer #(
  parameter int W = 17
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         tick,
  input  wire logic         clear,
  input  wire logic [W-1:0] limit,
  output logic              expired
);

  logic [W-1:0] count;

  // counts ticks since the last clear, holds at full scale
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick && count != {W{1'b1}}) begin
      count <= count + 1'b1;
    end
  end

  // a limit of zero expires at once
  assign expired = (count >= limit);

endmodule

`default_nettype wire

// File: verilog/mvrc_pkg.sv
// types shared by the reclose sequencer files
// assumes mvrc_regs.svh is compiled alongside
package mvrc_pkg;

  // sequencer states, one-hot
  typedef enum logic [9:0] {
    MVRC_IDLE    = 10'h001,
    MVRC_ARMED   = 10'h002,
    MVRC_DELAY   = 10'h004,
    MVRC_DEAD    = 10'h008,
    MVRC_CBWAIT  = 10'h010,
    MVRC_SYNCW   = 10'h020,
    MVRC_SWSYNC  = 10'h040,
    MVRC_CLOSE   = 10'h080,
    MVRC_RECLAIM = 10'h100,
    MVRC_FINAL   = 10'h200
  } mvrc_state_type;

endpackage

// File: verilog/mvrc_regs.svh
// register offsets, field positions, reset values and timing counts of the reclose sequencer
// assumes a 32-bit register port with byte addresses, one word per register
`ifndef MVRC_REGS_SVH
`define MVRC_REGS_SVH

// clock rate and millisecond tick
`define MVRC_CLK_KHZ        250000
`define MVRC_TICK_MS        1
`define MVRC_TICK_CYCLES    (`MVRC_CLK_KHZ * `MVRC_TICK_MS)

// widths
`define MVRC_AW             8
`define MVRC_TW             17

// register byte offsets
`define MVRC_CTRL_OFS       8'h00
`define MVRC_STATUS_OFS     8'h04
`define MVRC_DEAD_OFS       8'h08
`define MVRC_RECLAIM_OFS    8'h28
`define MVRC_CLOSE_OFS      8'h2c
`define MVRC_MANBLK_OFS     8'h30
`define MVRC_STARTMAX_OFS   8'h34
`define MVRC_CBWAIT_OFS     8'h38
`define MVRC_SYNCWAIT_OFS   8'h3c
`define MVRC_SWWAIT_OFS     8'h40
`define MVRC_STARTDLY_OFS   8'h44

// control register fields
`define MVRC_CTRL_OP_BIT    0
`define MVRC_CTRL_SRC_BIT   1
`define MVRC_CTRL_EF_LSB    2
`define MVRC_CTRL_PH_LSB    5
`define MVRC_CTRL_ACC_LSB   8

// reset values, times in milliseconds
`define MVRC_CTRL_RST       12'h025
`define MVRC_DEAD_PH1_RST   17'd500
`define MVRC_DEAD_PH2_RST   17'd600
`define MVRC_DEAD_PH3_RST   17'd700
`define MVRC_DEAD_PH4_RST   17'd800
`define MVRC_DEAD_EF1_RST   17'd1000
`define MVRC_DEAD_EF2_RST   17'd2000
`define MVRC_DEAD_EF3_RST   17'd3000
`define MVRC_DEAD_EF4_RST   17'd4000
`define MVRC_RECLAIM_RST    17'd2000
`define MVRC_CLOSE_RST      17'd100
`define MVRC_MANBLK_RST     17'd1000
`define MVRC_STARTMAX_RST   17'd3000
`define MVRC_CBWAIT_RST     17'd1000
`define MVRC_SYNCWAIT_RST   17'd10000
`define MVRC_SWWAIT_RST     17'd10000
`define MVRC_STARTDLY_RST   17'd0

`endif

// File: verilog/mvrc_sequencer.sv
// medium-voltage auto-reclose sequencer with its register port
// assumes all inputs synchronous to core_clk and a 250 MHz clock
//
// Overview of operation
// R1: at most four reclose shots per fault sequence, never a fifth close
// R2: per-shot dead times, separate sets for earth and phase faults
// R3: every shot recloses all three phases together
// R4: dead time starts on trip reset or breaker open; expiry leads to close
// R5: pickup within reclaim time advances to the next enabled shot
// R6: fault persisting after last shot gives final trip, no further close
// R7: no pickup within reclaim time returns to idle, first shot again
// R8: breaker ready awaited at most the supervision time, else abandon
// R9: per-shot bits flag an accelerated trip for external logic
// R10: close pulse lasts close time, withdrawn at once on any trip
// R11: separate shot counts for earth and phase faults, zero to four
// R12: operation off stops every start, dead time and close
// R13: block input stops starting or continuing reclosing
// R14: start source selects trip reset or breaker open start
// R15: outside logic supplies start input and breaker open condition
// R16: dead time counter started by start signal, optionally delayed
// R17: close only with sync release; after wait, request synchronous switching
// R18: synchronous switching not achieved in time resets to idle
// R19: manual close inhibits new sequences for a set time
// R20: timing within one percent or thirty milliseconds of setting
// R21: timers count a common millisecond tick; reset clears everything
// R22: block or operation off mid-sequence aborts and clears shot count
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mvrc_regs.svh"

module mvrc_sequencer #(
  parameter int TICK_CYCLES = `MVRC_TICK_CYCLES
) (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic [`MVRC_AW-1:0]   regAddr,
  input  wire logic [31:0]           regWdata,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output logic [31:0]                regRdata,
  input  wire logic                  protTrip,
  input  wire logic                  protPickup,
  input  wire logic                  earthFaultIn,
  input  wire logic                  recloseStartIn,
  input  wire logic                  breakerOpenIn,
  input  wire logic                  breakerReadyIn,
  input  wire logic                  syncReleaseIn,
  input  wire logic                  syncSwitchIn,
  input  wire logic                  blockIn,
  input  wire logic                  manualCloseIn,
  output logic                       closeCmd,
  output logic                       syncSwitchReq,
  output logic                       finalTrip,
  output logic                       accelTrip,
  output logic                       seqActive,
  output logic [1:0]                 shotNum,
  output mvrc_pkg::mvrc_state_type   seqState
);
  import mvrc_pkg::*;

  localparam int TW = `MVRC_TW;

  logic [11:0]   ctrl;
  logic [TW-1:0] deadTime [8];
  logic [TW-1:0] reclaimTime;
  logic [TW-1:0] closeTime;
  logic [TW-1:0] manBlockTime;
  logic [TW-1:0] startMaxTime;
  logic [TW-1:0] cbWaitTime;
  logic [TW-1:0] syncWaitTime;
  logic [TW-1:0] swWaitTime;
  logic [TW-1:0] startDelayTime;
  logic [17:0]   tickCount;
  logic          msTick;
  mvrc_state_type state;
  mvrc_state_type next_state;
  logic [1:0]    shot;
  logic [1:0]    next_shot;
  logic          faultEarth;
  logic          mcInhibit;
  logic          stExpired;
  logic          mcExpired;
  logic [TW-1:0] stLimit;
  logic [2:0]    shotLimit;
  logic          opOn;
  logic          startOnOpen;
  logic          startCond;
  logic          lastShot;

  assign opOn        = ctrl[`MVRC_CTRL_OP_BIT];
  assign startOnOpen = ctrl[`MVRC_CTRL_SRC_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // register port

  // software writes; settings change only through this port
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl           <= `MVRC_CTRL_RST;
      deadTime[0]    <= `MVRC_DEAD_PH1_RST;
      deadTime[1]    <= `MVRC_DEAD_PH2_RST;
      deadTime[2]    <= `MVRC_DEAD_PH3_RST;
      deadTime[3]    <= `MVRC_DEAD_PH4_RST;
      deadTime[4]    <= `MVRC_DEAD_EF1_RST;
      deadTime[5]    <= `MVRC_DEAD_EF2_RST;
      deadTime[6]    <= `MVRC_DEAD_EF3_RST;
      deadTime[7]    <= `MVRC_DEAD_EF4_RST;
      reclaimTime    <= `MVRC_RECLAIM_RST;
      closeTime      <= `MVRC_CLOSE_RST;
      manBlockTime   <= `MVRC_MANBLK_RST;
      startMaxTime   <= `MVRC_STARTMAX_RST;
      cbWaitTime     <= `MVRC_CBWAIT_RST;
      syncWaitTime   <= `MVRC_SYNCWAIT_RST;
      swWaitTime     <= `MVRC_SWWAIT_RST;
      startDelayTime <= `MVRC_STARTDLY_RST;
    end else if (regWrite) begin
      case (regAddr)
        `MVRC_CTRL_OFS:     ctrl           <= regWdata[11:0];
        `MVRC_RECLAIM_OFS:  reclaimTime    <= regWdata[TW-1:0];
        `MVRC_CLOSE_OFS:    closeTime      <= regWdata[TW-1:0];
        `MVRC_MANBLK_OFS:   manBlockTime   <= regWdata[TW-1:0];
        `MVRC_STARTMAX_OFS: startMaxTime   <= regWdata[TW-1:0];
        `MVRC_CBWAIT_OFS:   cbWaitTime     <= regWdata[TW-1:0];
        `MVRC_SYNCWAIT_OFS: syncWaitTime   <= regWdata[TW-1:0];
        `MVRC_SWWAIT_OFS:   swWaitTime     <= regWdata[TW-1:0];
        `MVRC_STARTDLY_OFS: startDelayTime <= regWdata[TW-1:0];
        default: begin
          for (int i = 0; i < 8; i++) begin
            if (regAddr == `MVRC_DEAD_OFS + 8'(4 * i)) begin
              deadTime[i] <= regWdata[TW-1:0]; // R2
            end
          end
        end
      endcase
    end
  end

  // read data stands in the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= '0;
    end else if (regRead) begin
      case (regAddr)
        `MVRC_CTRL_OFS:     regRdata <= {20'h0, ctrl};
        `MVRC_STATUS_OFS:   regRdata <= {15'h0, mcInhibit, faultEarth, shot,
                                         accelTrip, finalTrip, closeCmd, state};
        `MVRC_RECLAIM_OFS:  regRdata <= {15'h0, reclaimTime};
        `MVRC_CLOSE_OFS:    regRdata <= {15'h0, closeTime};
        `MVRC_MANBLK_OFS:   regRdata <= {15'h0, manBlockTime};
        `MVRC_STARTMAX_OFS: regRdata <= {15'h0, startMaxTime};
        `MVRC_CBWAIT_OFS:   regRdata <= {15'h0, cbWaitTime};
        `MVRC_SYNCWAIT_OFS: regRdata <= {15'h0, syncWaitTime};
        `MVRC_SWWAIT_OFS:   regRdata <= {15'h0, swWaitTime};
        `MVRC_STARTDLY_OFS: regRdata <= {15'h0, startDelayTime};
        default: begin
          regRdata <= '0;
          for (int i = 0; i < 8; i++) begin
            if (regAddr == `MVRC_DEAD_OFS + 8'(4 * i)) begin
              regRdata <= {15'h0, deadTime[i]};
            end
          end
        end
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // millisecond tick and timers

  // one free tick for every timer; phase error stays under one millisecond
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tickCount <= '0;
      msTick    <= 1'b0;
    end else if (tickCount == 18'(TICK_CYCLES - 1)) begin
      tickCount <= '0; // R21
      msTick    <= 1'b1; // R20
    end else begin
      tickCount <= tickCount + 1'b1;
      msTick    <= 1'b0;
    end
  end

  // limit of the running state, dead time picked by fault type and shot
  always_comb begin
    case (state)
      MVRC_ARMED:   stLimit = startMaxTime;
      MVRC_DELAY:   stLimit = startDelayTime; // R16
      MVRC_DEAD:    stLimit = deadTime[{faultEarth, shot}]; // R2
      MVRC_CBWAIT:  stLimit = cbWaitTime;
      MVRC_SYNCW:   stLimit = syncWaitTime;
      MVRC_SWSYNC:  stLimit = swWaitTime;
      MVRC_CLOSE:   stLimit = closeTime;
      MVRC_RECLAIM: stLimit = reclaimTime;
      default:      stLimit = '0;
    endcase
  end

  // state timer restarts on every state change
  mvrc_ms_timer #(.W(TW)) stateTimer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick     (msTick),
    .clear    (next_state != state),
    .limit    (stLimit),
    .expired  (stExpired)
  );

  // manual close hold-off timer, retriggered while the input stands
  mvrc_ms_timer #(.W(TW)) manCloseTimer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick     (msTick),
    .clear    (manualCloseIn),
    .limit    (manBlockTime),
    .expired  (mcExpired)
  );

  // inhibit set by manual close wins over its own expiry
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mcInhibit <= 1'b0;
    end else if (manualCloseIn) begin
      mcInhibit <= 1'b1; // R19
    end else if (mcExpired) begin
      mcInhibit <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer

  // shots allowed for the latched fault type, values above four clamp
  always_comb begin
    shotLimit = faultEarth ? ctrl[`MVRC_CTRL_EF_LSB +: 3] : ctrl[`MVRC_CTRL_PH_LSB +: 3];
    if (shotLimit > 3'd4) begin
      shotLimit = 3'd4; // R1 R11
    end
  end

  assign lastShot  = ({1'b0, shot} + 3'd1 >= shotLimit);
  // outside logic owns the start input and the breaker-open condition
  assign startCond = recloseStartIn && (startOnOpen ? breakerOpenIn : !protTrip); // R4 R14 R15

  // next state; abort by block or operation off has top priority
  always_comb begin
    next_state = state;
    next_shot  = shot;
    if (!opOn || blockIn) begin
      next_state = MVRC_IDLE; // R12 R13 R22
    end else begin
      case (state)
        MVRC_IDLE: begin
          if (protTrip && !mcInhibit) begin
            next_state = MVRC_ARMED;
          end
        end
        MVRC_ARMED: begin
          if (shotLimit == 3'd0) begin
            next_state = MVRC_IDLE; // R11
          end else if (startCond) begin
            next_state = MVRC_DELAY; // R4
          end else if (stExpired) begin
            next_state = MVRC_IDLE;
          end
        end
        MVRC_DELAY: begin
          if (stExpired) begin
            next_state = MVRC_DEAD; // R16
          end
        end
        MVRC_DEAD: begin
          if (stExpired) begin
            next_state = MVRC_CBWAIT; // R4
          end
        end
        MVRC_CBWAIT: begin
          if (breakerReadyIn) begin
            next_state = MVRC_SYNCW;
          end else if (stExpired) begin
            next_state = MVRC_IDLE; // R8
          end
        end
        MVRC_SYNCW: begin
          if (syncReleaseIn) begin
            next_state = MVRC_CLOSE; // R17
          end else if (stExpired) begin
            next_state = MVRC_SWSYNC; // R17
          end
        end
        MVRC_SWSYNC: begin
          if (syncSwitchIn) begin
            next_state = MVRC_CLOSE;
          end else if (stExpired) begin
            next_state = MVRC_IDLE; // R18
          end
        end
        MVRC_CLOSE: begin
          if (protTrip || stExpired) begin
            next_state = MVRC_RECLAIM; // R10
          end
        end
        MVRC_RECLAIM: begin
          if (protPickup || protTrip) begin
            if (lastShot) begin
              next_state = MVRC_FINAL; // R6
            end else begin
              next_state = MVRC_ARMED; // R5
              next_shot  = shot + 2'd1;
            end
          end else if (stExpired) begin
            next_state = MVRC_IDLE; // R7
          end
        end
        MVRC_FINAL: begin
          if (!protTrip && !protPickup) begin
            next_state = MVRC_IDLE;
          end
        end
        default: next_state = MVRC_IDLE;
      endcase
    end
    if (next_state == MVRC_IDLE) begin
      next_shot = 2'd0; // R7 R22
    end
  end

  // state, shot index and fault type latched at the first trip
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state      <= MVRC_IDLE; // R21
      shot       <= 2'd0;
      faultEarth <= 1'b0;
    end else begin
      state <= next_state;
      shot  <= next_shot;
      if (state == MVRC_IDLE && next_state == MVRC_ARMED) begin
        faultEarth <= earthFaultIn; // R2
      end
    end
  end

  // outputs from flops, following the next state so they align with it;
  // one close line drives all three poles, there is no per-phase close
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      closeCmd      <= 1'b0;
      syncSwitchReq <= 1'b0;
      finalTrip     <= 1'b0;
      accelTrip     <= 1'b0;
      seqActive     <= 1'b0;
      shotNum       <= 2'd0;
      seqState      <= MVRC_IDLE;
    end else begin
      closeCmd      <= (next_state == MVRC_CLOSE); // R3 R10
      syncSwitchReq <= (next_state == MVRC_SWSYNC); // R17
      finalTrip     <= (next_state == MVRC_FINAL); // R6
      accelTrip     <= ctrl[`MVRC_CTRL_ACC_LSB + next_shot] &&
                       (next_state == MVRC_CLOSE || next_state == MVRC_RECLAIM); // R9
      seqActive     <= (next_state != MVRC_IDLE);
      shotNum       <= next_shot;
      seqState      <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic [2:0] closesInSeq;

  // close pulses issued since the sequence left idle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      closesInSeq <= '0;
    end else if (state == MVRC_IDLE) begin
      closesInSeq <= '0;
    end else if (state != MVRC_CLOSE && next_state == MVRC_CLOSE) begin
      closesInSeq <= closesInSeq + 3'd1;
    end
  end

  sequence reclaimQuiet;
    state == MVRC_RECLAIM && stExpired && !protPickup && !protTrip && opOn && !blockIn;
  endsequence

  // a zero close time legally gives a one-cycle pulse, an abort in the same cycle no pulse
  sequence closeRequested;
    opOn && !blockIn && closeTime != '0 &&
    ((state == MVRC_SYNCW && syncReleaseIn) || (state == MVRC_SWSYNC && syncSwitchIn));
  endsequence

  close_count_a: assert property (closesInSeq <= 3'd4) // R1
    else $error("more than four closes in one sequence");
  close_cause_a: assert property ($rose(closeCmd) |-> $past(state == MVRC_SYNCW ||
                                  state == MVRC_SWSYNC) && $past(opOn)) // R17
    else $error("close issued without sync release path");
  close_withdraw_a: assert property (closeCmd && protTrip |=> !closeCmd) // R10
    else $error("close not withdrawn on trip");
  block_abort_a: assert property (blockIn |=> !closeCmd && state == MVRC_IDLE && shot == 2'd0) // R13
    else $error("block did not abort sequence");
  op_off_a: assert property (!opOn |=> state == MVRC_IDLE ##1 !closeCmd) // R12
    else $error("operation off did not stop sequence");
  reclaim_idle_a: assert property (reclaimQuiet |=> state == MVRC_IDLE && shot == 2'd0) // R7
    else $error("reclaim expiry did not return to idle");
  final_trip_a: assert property ($rose(finalTrip) |-> $past(state == MVRC_RECLAIM && lastShot)) // R6
    else $error("final trip outside last reclaim");
  cb_wait_a: assert property (state == MVRC_CBWAIT && stExpired && !breakerReadyIn
                              |=> state == MVRC_IDLE) // R8
    else $error("breaker ready wait not abandoned");
  sync_fail_a: assert property (state == MVRC_SWSYNC && stExpired && !syncSwitchIn
                                |=> state == MVRC_IDLE ##1 !closeCmd) // R18
    else $error("failed sync switching did not reset");
  man_inhibit_a: assert property (mcInhibit && state == MVRC_IDLE |=> state == MVRC_IDLE) // R19
    else $error("sequence started during manual close hold-off");
  close_len_a: assert property (closeRequested ##1 (!protTrip && opOn && !blockIn) [*2]
                                |-> closeCmd) // R10
    else $error("close pulse cut short");

endmodule

`default_nettype wire
